// >>> hdl/pec_pkg.sv
// pec_pkg: register offsets, field positions, reset values and event
// encodings shared by the event counter bank and its counter units.
// assumes: included before any pec_ module or interface is compiled.
package pec_pkg;

  // register addresses of the two contiguous blocks
  localparam logic [31:0] CTR_BLOCK_BASE = 32'h0000_00c1;
  localparam logic [31:0] SEL_BLOCK_BASE = 32'h0000_0186;

  // selector field positions
  localparam int SEL_EVT_LO   = 0;
  localparam int SEL_UMASK_LO = 8;
  localparam int SEL_USR_BIT  = 16;
  localparam int SEL_OS_BIT   = 17;
  localparam int SEL_EDGE_BIT = 18;
  localparam int SEL_PIN_BIT  = 19;
  localparam int SEL_INT_BIT  = 20;
  localparam int SEL_RSV_BIT  = 21;
  localparam int SEL_EN_BIT   = 22;
  localparam int SEL_INV_BIT  = 23;
  localparam int SEL_THRESHOLD_FIELD_LO = 24;
  localparam int SEXT_BIT     = 31;

  // reset values
  localparam logic [31:0] SEL_RESET = 32'h0000_0000;

  // enumeration word field positions
  localparam int LEAF_VER_LO  = 0;
  localparam int LEAF_NCTR_LO = 8;
  localparam int LEAF_WID_LO  = 16;
  localparam int LEAF_NEVT_LO = 24;

  // predefined event table: code and unit mask per vector position
  localparam int          NUM_PREDEF = 8;
  localparam logic [7:0] EVT_CODE  [NUM_PREDEF] = '{
    8'h3c, 8'hc0, 8'h3c, 8'h2e, 8'h2e, 8'hc4, 8'hc5, 8'ha4};
  localparam logic [7:0] EVT_UMASK [NUM_PREDEF] = '{
    8'h00, 8'h00, 8'h01, 8'h4f, 8'h41, 8'h00, 8'h00, 8'h01};
  localparam int EVT_CORE_CYC = 0;
  localparam int EVT_REF_CYC  = 2;

endpackage

// >>> hdl/pec_ctr_if.sv
// pec_ctr_if: carries one selector/counter pair between the bank and a
// counter unit. assumes both ends share clk and the bank drives strobes.
`timescale 1ns/10ps
interface pec_ctr_if #(
  parameter int CTR_W = 40,
  parameter int OCC_W = 4
);
  logic              wr_sel;    // selector write strobe
  logic              wr_ctr;    // counter write strobe
  logic [31:0]       wdata;     // low word of the write value
  logic [OCC_W-1:0]  occ;       // occurrences of selected event
  logic              priv_ok;   // privilege filter passes
  logic [31:0]       sel;       // selector contents
  logic [CTR_W-1:0]  ctr;       // counter contents
  logic              pin_pulse; // monitor pin pulse
  logic              irq_pulse; // overflow interrupt pulse

  modport bank (output wr_sel, wr_ctr, wdata, occ, priv_ok,
                input sel, ctr, pin_pulse, irq_pulse);
  modport unit (input wr_sel, wr_ctr, wdata, occ, priv_ok,
                output sel, ctr, pin_pulse, irq_pulse);
endinterface

// >>> hdl/pec_ctr_unit.sv
// pec_ctr_unit: one event selector and its paired counter.
// assumes: CTR_W above 32, strobes from logic on the same clock.
`timescale 1ns/10ps
module pec_ctr_unit import pec_pkg::*; #(
  parameter int   CTR_W      = 40,
  parameter int   OCC_W      = 4,
  parameter logic PIN_LEGACY = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  pec_ctr_if.unit  u
);

  // writable selector bits; pin bit only on the legacy form
  localparam logic [31:0] SEL_WMASK = ~((32'h1 << SEL_RSV_BIT) |
    (PIN_LEGACY ? 32'h0 : (32'h1 << SEL_PIN_BIT)));

  logic [31:0]      sel_ff;   // selector
  logic [CTR_W-1:0] ctr_ff;   // counter
  logic             prev_ff;  // last qualified condition, for edges
  logic             pin_ff;   // monitor pin pulse
  logic             irq_ff;   // overflow interrupt pulse

  logic [7:0]       threshold_field;    // threshold
  logic             en;       // counting enabled
  logic [OCC_W-1:0] occ_q;    // occurrences after privilege filter
  logic [OCC_W-1:0] lvl;      // per-cycle amount before edge stage
  logic [OCC_W-1:0] inc;      // amount added this cycle
  logic [CTR_W:0]   sum;      // counter plus carry
  logic             ovf;      // carry out of top bit

  // threshold, invert, edge and accumulate
  always_comb begin
    threshold_field = sel_ff[SEL_THRESHOLD_FIELD_LO +: 8];
    en    = sel_ff[SEL_EN_BIT];
    occ_q = u.priv_ok ? u.occ : '0;
    if (threshold_field == 8'h00) begin
      lvl = occ_q;
    end else if (sel_ff[SEL_INV_BIT]) begin
      lvl = OCC_W'({7'h00, (8'(occ_q) < threshold_field)});
    end else begin
      lvl = OCC_W'({7'h00, (8'(occ_q) >= threshold_field)});
    end
    if (sel_ff[SEL_EDGE_BIT]) begin
      inc = OCC_W'({7'h00, ((lvl != '0) && !prev_ff)});
    end else begin
      inc = lvl;
    end
    sum = {1'b0, ctr_ff} + (CTR_W + 1)'(inc);
    ovf = en && sum[CTR_W];
  end

  // selector register
  always_ff @(posedge clk) begin
    if (rst) begin
      sel_ff <= SEL_RESET;
    end else if (u.wr_sel) begin
      sel_ff <= u.wdata & SEL_WMASK;
    end
  end

  // counter: a write wins over counting
  always_ff @(posedge clk) begin
    if (rst) begin
      ctr_ff <= '0;
    end else if (u.wr_ctr) begin
      ctr_ff <= {{(CTR_W-32){u.wdata[SEXT_BIT]}}, u.wdata};
    end else if (en) begin
      ctr_ff <= sum[CTR_W-1:0];
    end
  end

  // edge history, cleared while disabled
  always_ff @(posedge clk) begin
    if (rst) begin
      prev_ff <= 1'b0;
    end else begin
      prev_ff <= en && (lvl != '0);
    end
  end

  // pin and interrupt pulses, one clock each
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      pin_ff <= PIN_LEGACY && en && (sel_ff[SEL_PIN_BIT] ?
                (inc != '0) : ovf);
      irq_ff <= ovf && sel_ff[SEL_INT_BIT];
    end
  end

  assign u.sel       = sel_ff;
  assign u.ctr       = ctr_ff;
  assign u.pin_pulse = pin_ff;
  assign u.irq_pulse = irq_ff;

endmodule

// >>> hdl/pec_top.sv
// pec_top: bank of programmable event counters, one private set of
// selector/counter pairs per logical processor, reached over a
// register read/write port, with the enumeration words alongside.
// assumes: event occurrence inputs and privilege level come from logic
// on clk; the stop-clock pin is asynchronous and is synchronised here.
`timescale 1ns/10ps

module pec_top import pec_pkg::*; #(
  parameter int         N_LP        = 2,     // logical processors
  parameter int         N_CTR       = 4,     // pairs per processor
  parameter int         CTR_W       = 40,    // counter width, > 32
  parameter int         OCC_W       = 4,     // occurrence count width
  parameter logic [7:0] VERSION     = 8'h01, // facility version
  parameter logic [7:0] EVT_UNAVAIL = 8'h00, // set bit: event missing
  parameter logic       PIN_LEGACY  = 1'b1   // pin control writable
) (
  input  wire logic                                  clk,
  input  wire logic                                  rst,
  // register read/write port
  input  wire logic                                  reg_req,
  input  wire logic                                  reg_we,
  input  wire logic [$clog2(N_LP+1)-1:0]             reg_lp,
  input  wire logic [31:0]                           reg_addr,
  input  wire logic [63:0]                           reg_wdata,
  output logic                                       reg_ack_ff,
  output logic                                       reg_fault_ff,
  output logic [63:0]                                reg_rdata_ff,
  // enumeration words of the feature query leaf
  output logic [31:0]                                leaf_eax_ff,
  output logic [31:0]                                leaf_ebx_ff,
  // per-processor state
  input  wire logic [N_LP-1:0][1:0]                  priv_level,
  input  wire logic [N_LP-1:0]                       idle_not_active,
  input  wire logic [N_LP-1:0]                       halt_instr,
  input  wire logic                                  stop_clock_pin,
  input  wire logic [N_LP-1:0]                       thermal_throttle_first,
  input  wire logic [N_LP-1:0]                       freq_switch,
  input  wire logic                                  ref_tick,
  // occurrences per cycle of predefined events, by vector position
  input  wire logic [N_LP-1:0][NUM_PREDEF-1:0][OCC_W-1:0] evt_occ,
  // outputs
  output logic [N_LP-1:0][N_CTR-1:0]                 monitor_pin_ff,
  output logic [N_LP-1:0]                            ovf_irq_ff
);

  localparam int LPW = $clog2(N_LP+1);
  localparam int CW  = $clog2(N_CTR+1);

  // decoded register address
  typedef struct packed {
    logic          hit;    // address inside either block
    logic          is_sel; // selector block, else counter block
    logic [CW-1:0] idx;    // pair index
  } pec_dec_t;

  // address decode: both blocks, index within block
  function automatic pec_dec_t pec_decode(input logic [31:0] addr);
    pec_dec_t d;
    d = '0;
    if (addr >= CTR_BLOCK_BASE &&
        addr <  CTR_BLOCK_BASE + 32'(N_CTR)) begin
      d.hit = 1'b1;
      d.idx = CW'(addr - CTR_BLOCK_BASE);
    end else if (addr >= SEL_BLOCK_BASE &&
                 addr <  SEL_BLOCK_BASE + 32'(N_CTR)) begin
      d.hit    = 1'b1;
      d.is_sel = 1'b1;
      d.idx    = CW'(addr - SEL_BLOCK_BASE);
    end
    return d;
  endfunction

  // event unit selection by code and unit mask
  function automatic logic [OCC_W-1:0] pec_pick(
    input logic [7:0]                           code,
    input logic [7:0]                           umask,
    input logic [NUM_PREDEF-1:0][OCC_W-1:0]     occ
  );
    logic [OCC_W-1:0] r;
    r = '0;
    for (int i = 0; i < NUM_PREDEF; i++) begin
      // unimplemented or unavailable codes count nothing
      if (code == EVT_CODE[i] && umask == EVT_UMASK[i] &&
          !EVT_UNAVAIL[i]) begin
        r = occ[i];
      end
    end
    return r;
  endfunction

  // stop-clock pin synchroniser
  logic stop_clock_pin_meta_ff; // first stage, read only by the second
  logic stop_clock_pin_sync_ff; // usable level

  // collected unit state for the read mux
  logic [N_LP-1:0][N_CTR-1:0][31:0]      sel_q;  // selectors
  logic [N_LP-1:0][N_CTR-1:0][CTR_W-1:0] ctr_q;  // counters
  logic [N_LP-1:0][N_CTR-1:0]            pin_q;  // pin pulses
  logic [N_LP-1:0][N_CTR-1:0]            irq_q;  // overflow pulses

  pec_dec_t    dec;       // decode of current address
  logic        lp_ok;     // processor index in range
  logic        wr_bad;    // selector write with upper bits set
  logic        acc_ok;    // access accepted
  logic [63:0] rd_val;    // value for a read

  // two flip-flops on the asynchronous pin
  always_ff @(posedge clk) begin
    if (rst) begin
      stop_clock_pin_meta_ff <= 1'b0;
      stop_clock_pin_sync_ff <= 1'b0;
    end else begin
      stop_clock_pin_meta_ff <= stop_clock_pin;
      stop_clock_pin_sync_ff <= stop_clock_pin_meta_ff;
    end
  end

  // per-processor private sets of pairs
  genvar lp, c;
  generate
    for (lp = 0; lp < N_LP; lp++) begin : g_lp
      logic                               running; // core clock runs
      logic                               cnt_usr; // at levels 1-3
      logic [NUM_PREDEF-1:0][OCC_W-1:0]   occ_v;   // event vector

      // core clock considered running unless stopped for any reason
      always_comb begin
        running = !idle_not_active[lp] && !halt_instr[lp] &&
                  !stop_clock_pin_sync_ff && !thermal_throttle_first[lp] &&
                  !freq_switch[lp];
        cnt_usr = (priv_level[lp] != 2'b00);
      end

      // event vector: cycle events built here, the rest from inputs
      always_comb begin
        occ_v = evt_occ[lp];
        // core cycles one per running core clock; reference cycles one per ref_tick while running
        occ_v[EVT_CORE_CYC] = OCC_W'(running);
        occ_v[EVT_REF_CYC]  = OCC_W'(running && ref_tick);
      end

      for (c = 0; c < N_CTR; c++) begin : g_ctr
        pec_ctr_if #(.CTR_W(CTR_W), .OCC_W(OCC_W)) pif ();

        // write strobes only for this processor and index
        always_comb begin
          pif.wr_sel  = acc_ok && reg_we && dec.is_sel &&
                        reg_lp == LPW'(lp) && dec.idx == CW'(c);
          pif.wr_ctr  = acc_ok && reg_we && !dec.is_sel &&
                        reg_lp == LPW'(lp) && dec.idx == CW'(c);
          pif.wdata   = reg_wdata[31:0];
          pif.occ     = pec_pick(pif.sel[SEL_EVT_LO +: 8],
                                 pif.sel[SEL_UMASK_LO +: 8],
                                 occ_v);
          pif.priv_ok = (pif.sel[SEL_USR_BIT] && cnt_usr) ||
                        (pif.sel[SEL_OS_BIT] && !cnt_usr);
        end

        pec_ctr_unit #(
          .CTR_W      (CTR_W),
          .OCC_W      (OCC_W),
          .PIN_LEGACY (PIN_LEGACY)
        ) u_unit (
          .clk (clk),
          .rst (rst),
          .u   (pif.unit)
        );

        assign sel_q[lp][c] = pif.sel;
        assign ctr_q[lp][c] = pif.ctr;
        assign pin_q[lp][c] = pif.pin_pulse;
        assign irq_q[lp][c] = pif.irq_pulse;
      end
    end
  endgenerate

  // access check and read value
  always_comb begin
    dec    = pec_decode(reg_addr);
    lp_ok  = (32'(reg_lp) < 32'(N_LP));
    // selector upper word is reserved; a write there is refused
    wr_bad = reg_we && dec.is_sel && (reg_wdata[63:32] != 32'h0);
    acc_ok = reg_req && dec.hit && lp_ok && !wr_bad;
    rd_val = '0;
    if (dec.hit && lp_ok) begin
      if (dec.is_sel) begin
        rd_val = {32'h0, sel_q[reg_lp][dec.idx]};
      end else begin
        // only the implemented counter bits read back
        rd_val = 64'(ctr_q[reg_lp][dec.idx]);
      end
    end
  end

  // register port answer, one clock after the request
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_ack_ff   <= 1'b0;
      reg_fault_ff <= 1'b0;
      reg_rdata_ff <= 64'h0;
    end else begin
      reg_ack_ff   <= reg_req;
      reg_fault_ff <= reg_req && !acc_ok;
      // writes and faults return zero data
      reg_rdata_ff <= (acc_ok && !reg_we) ? rd_val : 64'h0;
    end
  end

  // enumeration words, held constant from reset
  always_ff @(posedge clk) begin
    if (rst) begin
      leaf_eax_ff <= 32'h0;
      leaf_ebx_ff <= 32'h0;
    end else begin
      leaf_eax_ff[LEAF_VER_LO  +: 8] <= VERSION;
      leaf_eax_ff[LEAF_NCTR_LO +: 8] <= 8'(N_CTR);
      leaf_eax_ff[LEAF_WID_LO  +: 8] <= 8'(CTR_W);
      leaf_eax_ff[LEAF_NEVT_LO +: 8] <= 8'(NUM_PREDEF);
      leaf_ebx_ff <= {24'h0, EVT_UNAVAIL};
    end
  end

  // monitor pins and per-processor overflow interrupt
  always_ff @(posedge clk) begin
    if (rst) begin
      monitor_pin_ff <= '0;
      ovf_irq_ff     <= '0;
    end else begin
      monitor_pin_ff <= pin_q;
      for (int i = 0; i < N_LP; i++) begin
        ovf_irq_ff[i] <= |irq_q[i];
      end
    end
  end

endmodule

// >>> verif/pec_top_monitor.sv
// pec_top_monitor: port assertions for the event counter bank.
// assumes: bound into pec_top; one clock, rst synchronous active high.
`timescale 1ns/10ps
module pec_top_monitor import pec_pkg::*; #(
  parameter int         N_LP        = 2,
  parameter int         N_CTR       = 4,
  parameter int         CTR_W       = 40,
  parameter logic [7:0] VERSION     = 8'h01,
  parameter logic [7:0] EVT_UNAVAIL = 8'h00
) (
  input wire logic                      clk,
  input wire logic                      rst,
  input wire logic                      reg_req,
  input wire logic                      reg_we,
  input wire logic [$clog2(N_LP+1)-1:0] reg_lp,
  input wire logic [31:0]               reg_addr,
  input wire logic [63:0]               reg_wdata,
  input wire logic                      reg_ack_ff,
  input wire logic                      reg_fault_ff,
  input wire logic [63:0]               reg_rdata_ff,
  input wire logic [31:0]               leaf_eax_ff,
  input wire logic [31:0]               leaf_ebx_ff
);
  localparam logic [63:0] MASK = (64'h1 << CTR_W) - 64'h1; // valid bits
  logic        in_ctr; // address in the counter block
  logic        wr_ctr; // counter write that will be taken
  logic        rd_ctr; // counter read that will be taken
  logic [63:0] exp_ff; // value a read-back should give

  assign in_ctr = reg_addr >= CTR_BLOCK_BASE &&
                  reg_addr < CTR_BLOCK_BASE + N_CTR;
  assign wr_ctr = reg_req && reg_we && in_ctr && reg_lp < N_LP;
  assign rd_ctr = reg_req && !reg_we && in_ctr && reg_lp < N_LP;

  // low word kept, upper bits copied from bit 31, cut to width
  always_ff @(posedge clk) begin
    if (wr_ctr) begin
      exp_ff <= {{32{reg_wdata[31]}}, reg_wdata[31:0]} & MASK;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_version;
    !$past(rst) |-> leaf_eax_ff[7:0] == VERSION && VERSION != 8'h00;
  endproperty
  a_version: assert property (p_version)
    else $error("version field wrong");
  property p_ctr_count;
    !$past(rst) |-> leaf_eax_ff[15:8] == 8'(N_CTR);
  endproperty
  a_ctr_count: assert property (p_ctr_count)
    else $error("counter count field wrong");
  property p_width;
    !$past(rst) |-> leaf_eax_ff[23:16] == 8'(CTR_W);
  endproperty
  a_width: assert property (p_width)
    else $error("counter width field wrong");
  property p_events;
    !$past(rst) |-> leaf_eax_ff[31:24] == 8'h08 &&
                    leaf_ebx_ff == {24'h0, EVT_UNAVAIL};
  endproperty
  a_events: assert property (p_events)
    else $error("event enumeration wrong");
  // every access is answered exactly one cycle later, no other answer
  property p_ack;
    !$past(rst) |-> reg_ack_ff == $past(reg_req);
  endproperty
  a_ack: assert property (p_ack)
    else $error("access answer out of step");
  property p_lp_fault;
    reg_req && reg_lp >= N_LP |=> reg_fault_ff && reg_rdata_ff == 64'h0;
  endproperty
  a_lp_fault: assert property (p_lp_fault)
    else $error("unknown processor not refused");
  // holds while the pair is disabled, as software must ensure
  property p_sext;
    wr_ctr ##2 (rd_ctr && reg_addr == $past(reg_addr, 2) &&
                reg_lp == $past(reg_lp, 2)) |=> reg_rdata_ff == exp_ff;
  endproperty
  a_sext: assert property (p_sext)
    else $error("counter read-back not sign extended");
  property p_rd_width;
    $past(rd_ctr) |-> reg_rdata_ff[63:CTR_W] == '0;
  endproperty
  a_rd_width: assert property (p_rd_width)
    else $error("counter read wider than reported");
endmodule

bind pec_top pec_top_monitor #(
  .N_LP(N_LP), .N_CTR(N_CTR), .CTR_W(CTR_W), .VERSION(VERSION),
  .EVT_UNAVAIL(EVT_UNAVAIL)
) i_pec_top_monitor (
  .clk(clk), .rst(rst), .reg_req(reg_req), .reg_we(reg_we),
  .reg_lp(reg_lp), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_ack_ff(reg_ack_ff), .reg_fault_ff(reg_fault_ff),
  .reg_rdata_ff(reg_rdata_ff), .leaf_eax_ff(leaf_eax_ff),
  .leaf_ebx_ff(leaf_ebx_ff)
);

// >>> verif/test_pec_top.sv
// test_pec_top: directed scenarios for the event counter bank.
// assumes: pec_top at default parameters with its monitor bound in.
`timescale 1ns/10ps
module test_pec_top;
  logic                 clk, rst, reg_req, reg_we, reg_ack_ff;
  logic                 reg_fault_ff, stop_clock_pin, ref_tick, flt_q;
  logic [1:0]           reg_lp, idle_not_active, halt_instr, ovf_irq_ff;
  logic [1:0]           thermal_throttle_first, freq_switch;
  logic [31:0]          reg_addr, leaf_eax_ff, leaf_ebx_ff;
  logic [63:0]          reg_wdata, reg_rdata_ff, rd_q;
  logic [1:0][1:0]      priv_level;     // privilege per processor
  logic [1:0][7:0][3:0] evt_occ;        // occurrences per event
  logic [1:0][3:0]      monitor_pin_ff; // pin pulses per pair
  int                   num_errors, checked, irq_n, pin_n;

  pec_top i_pec_top (
    .clk(clk), .rst(rst), .reg_req(reg_req), .reg_we(reg_we),
    .reg_lp(reg_lp), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_ack_ff(reg_ack_ff), .reg_fault_ff(reg_fault_ff),
    .reg_rdata_ff(reg_rdata_ff), .leaf_eax_ff(leaf_eax_ff),
    .leaf_ebx_ff(leaf_ebx_ff), .priv_level(priv_level),
    .idle_not_active(idle_not_active), .halt_instr(halt_instr),
    .stop_clock_pin(stop_clock_pin),
    .thermal_throttle_first(thermal_throttle_first),
    .freq_switch(freq_switch), .ref_tick(ref_tick), .evt_occ(evt_occ),
    .monitor_pin_ff(monitor_pin_ff), .ovf_irq_ff(ovf_irq_ff)
  );

  // 8 ns clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // pulse tallies: interrupt of processor 0, monitor pin of its pair 0
  always @(posedge clk) begin
    irq_n += ovf_irq_ff[0];
    pin_n += monitor_pin_ff[0][0];
  end

  task automatic chk(input logic [63:0] seen, input logic [63:0] want);
    checked++;
    if (seen !== want) begin
      num_errors++;
      $display("[FAIL] %0t got %h want %h", $time, seen, want);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // one register access, answer awaited under a bound
  task automatic acc(input logic we, input logic [1:0] lp,
                     input logic [31:0] a, input logic [63:0] d);
    int k;
    @(posedge clk);
    reg_req <= 1'b1;
    reg_we <= we;
    reg_lp <= lp;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk) reg_req <= 1'b0;
    #1;
    for (k = 0; k < 4 && reg_ack_ff !== 1'b1; k++) @(posedge clk) #1;
    if (reg_ack_ff !== 1'b1) begin
      num_errors++;
      finish_test();
    end else begin
      rd_q = reg_rdata_ff;
      flt_q = reg_fault_ff;
    end
  endtask

  // program pair 0 of processor 0, play nibbles of seq, read the count
  task automatic run(input logic [31:0] sel, input logic [63:0] init,
                     input int p, input logic [3:0] bg,
                     input logic [31:0] seq, input int n);
    int i;
    acc(1'b1, 2'd0, 32'h186, 64'h0);
    acc(1'b1, 2'd0, 32'hc1, init);
    @(posedge clk) evt_occ[0][p] <= bg;
    irq_n = 0;
    pin_n = 0;
    acc(1'b1, 2'd0, 32'h186, {32'h0, sel});
    repeat (2) @(posedge clk);
    for (i = 0; i < n; i++) begin
      @(posedge clk) evt_occ[0][p] <= seq[4*i +: 4];
    end
    @(posedge clk) evt_occ[0][p] <= bg;
    repeat (4) @(posedge clk);
    acc(1'b1, 2'd0, 32'h186, 64'h0);
    @(posedge clk) evt_occ[0][p] <= 4'h0;
    acc(1'b0, 2'd0, 32'hc1, 64'h0);
  endtask

  task automatic t_leaf();
    chk({32'h0, leaf_eax_ff}, 64'h0828_0401);
    chk({32'h0, leaf_ebx_ff}, 64'h0);
  endtask

  // write, read-back, privacy and refusals
  task automatic t_regs();
    acc(1'b1, 2'd0, 32'hc1, 64'h1234_5678_8000_1234);
    acc(1'b0, 2'd0, 32'hc1, 64'h0);
    chk(rd_q, 64'h0000_00ff_8000_1234);
    acc(1'b1, 2'd1, 32'hc1, 64'h5);
    acc(1'b0, 2'd0, 32'hc1, 64'h0);
    chk(rd_q, 64'h0000_00ff_8000_1234);
    acc(1'b0, 2'd1, 32'hc1, 64'h0);
    chk(rd_q, 64'h5);
    acc(1'b1, 2'd0, 32'hc4, 64'h7fff_ffff);
    acc(1'b0, 2'd0, 32'hc4, 64'h0);
    chk(rd_q, 64'h7fff_ffff);
    acc(1'b1, 2'd0, 32'h189, 64'hffff_ffff);
    acc(1'b0, 2'd0, 32'h189, 64'h0);
    chk(rd_q, 64'hffdf_ffff);
    acc(1'b1, 2'd0, 32'h189, 64'h1_0000_0000);
    chk({63'h0, flt_q}, 64'h1);
    acc(1'b0, 2'd0, 32'h189, 64'h0);
    chk(rd_q, 64'hffdf_ffff);
    acc(1'b1, 2'd0, 32'h189, 64'h0);
    acc(1'b0, 2'd0, 32'hc5, 64'h0);
    chk({63'h0, flt_q}, 64'h1);
    acc(1'b0, 2'd0, 32'h18a, 64'h0);
    chk({63'h0, flt_q}, 64'h1);
    acc(1'b0, 2'd2, 32'hc1, 64'h0);
    chk({63'h0, flt_q}, 64'h1);
  endtask

  // sum, threshold, inversion, edge, enable, code and mask
  task automatic t_count();
    run(32'h0043_00c0, 64'h0, 1, 4'h0, 32'h3333, 4);
    chk(rd_q, 64'd12);
    run(32'h0243_00c0, 64'h0, 1, 4'h1, 32'h3333, 4);
    chk(rd_q, 64'd4);
    run(32'h02c3_00c0, 64'h0, 1, 4'h3, 32'h3333, 4);
    chk(rd_q, 64'd0);
    run(32'h00c3_00c0, 64'h0, 1, 4'h0, 32'h3333, 4);
    chk(rd_q, 64'd12);
    run(32'h0047_00c0, 64'h0, 1, 4'h0, 32'h0111022, 7);
    chk(rd_q, 64'd2);
    run(32'h0003_00c0, 64'h0, 1, 4'h0, 32'h3333, 4);
    chk(rd_q, 64'd0);
    run(32'h0043_0011, 64'h0, 1, 4'h0, 32'h3333, 4);
    chk(rd_q, 64'd0);
    run(32'h0043_01c0, 64'h0, 1, 4'h0, 32'h3333, 4);
    chk(rd_q, 64'd0);
  endtask

  task automatic t_priv();
    @(posedge clk) priv_level[0] <= 2'd0;
    run(32'h0041_00c0, 64'h0, 1, 4'h0, 32'h3333, 4);
    chk(rd_q, 64'd0);
    run(32'h0042_00c0, 64'h0, 1, 4'h0, 32'h3333, 4);
    chk(rd_q, 64'd12);
    @(posedge clk) priv_level[0] <= 2'd2;
    run(32'h0041_00c0, 64'h0, 1, 4'h0, 32'h3333, 4);
    chk(rd_q, 64'd12);
    run(32'h0042_00c0, 64'h0, 1, 4'h0, 32'h3333, 4);
    chk(rd_q, 64'd0);
    @(posedge clk) priv_level[0] <= 2'd3;
  endtask

  // predefined encodings; reference cycles follow the tick
  task automatic t_table();
    logic [15:0] ev [8];
    int i;
    ev = '{16'h003c, 16'h00c0, 16'h013c, 16'h4f2e,
           16'h412e, 16'h00c4, 16'h00c5, 16'h01a4};
    for (i = 1; i < 8; i++) begin
      @(posedge clk) ref_tick <= (i == 2);
      run({16'h0043, ev[i]}, 64'h0, i, 4'h0, 32'h3333, 4);
      chk(rd_q, (i == 2) ? 64'd13 : 64'd12);
    end
  endtask

  // each stop condition freezes core cycles; none lets them run
  task automatic t_stop();
    logic [4:0] s;
    int k;
    for (k = 0; k < 6; k++) begin
      s = 5'h1 << k;
      @(posedge clk);
      idle_not_active[0] <= s[0];
      halt_instr[0] <= s[1];
      stop_clock_pin <= s[2];
      thermal_throttle_first[0] <= s[3];
      freq_switch[0] <= s[4];
      run(32'h0043_003c, 64'h0, 0, 4'h0, 32'h0, 6);
      chk(rd_q, (k == 5) ? 64'd15 : 64'd0);
    end
  endtask

  // wrap with interrupt and overflow pin, then per-event pin
  task automatic t_ovf();
    run(32'h0053_00c0, 64'hffff_ffff, 1, 4'h0, 32'h1, 1);
    chk(rd_q, 64'h0);
    chk(64'(irq_n), 64'd1);
    chk(64'(pin_n), 64'd1);
    run(32'h004b_00c0, 64'h0, 1, 4'h0, 32'h111, 3);
    chk(64'(pin_n), 64'd3);
    chk(64'(irq_n), 64'd0);
  endtask

  initial begin
    {num_errors, checked, irq_n, pin_n} = '0;
    {rst, reg_req, reg_we, reg_lp, reg_addr, reg_wdata} = '0;
    {idle_not_active, halt_instr, stop_clock_pin} = '0;
    {thermal_throttle_first, freq_switch, ref_tick, evt_occ} = '0;
    priv_level = 4'hf;
    rst = 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    t_leaf();
    t_regs();
    t_count();
    t_priv();
    t_table();
    t_stop();
    t_ovf();
    finish_test();
  end
endmodule
